// File: xcfg_params.svh
`ifndef XCFG_PARAMS_SVH
`define XCFG_PARAMS_SVH

// Register indices
`define XCFG_ADDR_ROUTE 8'h00
`define XCFG_ADDR_EMPH 8'h01
`define XCFG_ADDR_EQ 8'h02
`define XCFG_ADDR_CTRL 8'h03
`define XCFG_ADDR_STATUS 8'h04

// Reset values
`define XCFG_RST_ROUTE 8'h00
`define XCFG_RST_EMPH 8'h00
`define XCFG_RST_EQ 8'h00
`define XCFG_RST_CTRL 8'h0f

// Control register fields
`define XCFG_CTRL_KEEP_LSB 0
`define XCFG_CTRL_EQ_OVR 4
`define XCFG_CTRL_EMPH_OVR 5
`define XCFG_CTRL_MON_EN 6
`define XCFG_CTRL_SOFT_ON 7

// Pin-mode levels
`define XCFG_PIN_EMPH_ON 2'h2
`define XCFG_PIN_EQ_ON 2'h1

`endif

// File: xcfg_pkg.sv
package xcfg_pkg;
	typedef enum logic [1:0] {
		XCFG_LVL_OFF,
		XCFG_LVL_LOW,
		XCFG_LVL_MEDIUM,
		XCFG_LVL_HIGH
	} xcfg_level_type;

	typedef logic [1:0] xcfg_sel_type;
	typedef logic [7:0] xcfg_byte_type;
endpackage

// File: xcfg_crosspoint_regs.sv
`timescale 1ns/1ps
`include "xcfg_params.svh"
// Summary of operation
// - Five byte registers at indices 0..4; 0..3 read-write, 4 read-only.
// - Index 0 holds four 2-bit routing fields, one per output, reset 00.
// - Routing code n connects input n to that output.
// - Inputs unused by routing are powered down automatically; outputs never are.
// - Index 1 holds 2-bit emphasis field per output, reset 00.
// - Emphasis code decodes Off, Low, Medium, High.
// - Index 2 holds 2-bit equalizer field per input, reset 00.
// - Equalizer code decodes Off, Low, Medium, High.
// - Control bits 3:0 keep outputs on, reset 1111; zero powers output down.
// - Control bit 4 takes equalizer levels from register, not pins.
// - Control bit 5 takes emphasis levels from register, not pins.
// - Control bit 6 enables input monitors and receivers on all inputs.
// - With monitors enabled, auto shutdown never disables any input.
// - Control bit 7 is soft power on, reset 0; zero requests power down.
// - Device powered when power pin or soft power bit is high.
// - Index 4 reports input dropout; writes change nothing.
// - Without override, emphasis pin gives Off or Medium.
// - Without override, equalizer pin gives Off or Low.
// - Status bits 3:0 read 1 for valid signal, 0 for open input.
// - Output on if powered and kept on; input on if powered and routed, or monitored.
module xcfg_crosspoint_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register access from the bus slave engine
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	input wire xcfg_pkg::xcfg_byte_type reg_addr,
	input wire xcfg_pkg::xcfg_byte_type reg_wr_data,
	output xcfg_pkg::xcfg_byte_type reg_rd_data,
	// Device pins
	input wire logic power_pin_on,
	input wire logic [3:0] emphasis_sel_pin,
	input wire logic [3:0] eq_sel_pin,
	input wire logic [3:0] input_signal_valid,
	// Analog controls
	output logic device_powered,
	output logic [3:0] output_enable,
	output logic [3:0] input_enable,
	output logic input_monitor_on,
	output xcfg_pkg::xcfg_sel_type out_source [4],
	output xcfg_pkg::xcfg_level_type tx_emphasis [4],
	output xcfg_pkg::xcfg_level_type rx_equalizer [4]
);
	import xcfg_pkg::*;

	xcfg_byte_type route_select_reg;
	xcfg_byte_type tx_emphasis_level_reg;
	xcfg_byte_type rx_equalizer_level_reg;
	xcfg_byte_type power_and_override_control_reg;
	xcfg_byte_type reg_rd_data_reg;
	xcfg_byte_type reg_rd_data_next;
	logic [3:0] emph_sync1_reg, emph_sync2_reg, emph_sync3_reg, emph_reg;
	logic [3:0] eq_sync1_reg, eq_sync2_reg, eq_sync3_reg, eq_reg;
	logic [3:0] los_sync1_reg, los_sync2_reg, los_sync3_reg, los_reg;
	logic pwr_sync1_reg, pwr_sync2_reg, pwr_sync3_reg, pwr_reg;

	// Two-bit field n of a byte
	function automatic logic [1:0] field_of(input logic [7:0] b, input int n);
		field_of = b[2*n +: 2];
	endfunction

	// Accept pin change only once stages two and three agree
	function automatic logic [3:0] filt(input logic [3:0] s2, input logic [3:0] s3,
		input logic [3:0] cur);
		filt = (s2 == s3) ? s3 : cur;
	endfunction

	wire wr_route = reg_wr_stb && reg_addr == `XCFG_ADDR_ROUTE;
	wire wr_emph = reg_wr_stb && reg_addr == `XCFG_ADDR_EMPH;
	wire wr_eq = reg_wr_stb && reg_addr == `XCFG_ADDR_EQ;
	wire wr_ctrl = reg_wr_stb && reg_addr == `XCFG_ADDR_CTRL;

	wire [3:0] keep_on = power_and_override_control_reg[`XCFG_CTRL_KEEP_LSB +: 4];
	wire eq_pin_override = power_and_override_control_reg[`XCFG_CTRL_EQ_OVR];
	wire emphasis_pin_override = power_and_override_control_reg[`XCFG_CTRL_EMPH_OVR];
	wire input_monitor_enable = power_and_override_control_reg[`XCFG_CTRL_MON_EN];
	wire soft_power_on = power_and_override_control_reg[`XCFG_CTRL_SOFT_ON];

	wire powered_now = pwr_reg | soft_power_on;

	// Inputs that some output draws from
	logic [3:0] input_used;
	always_comb begin
		input_used = 4'h0;
		for (int n = 0; n < 4; n++) begin
			input_used[field_of(route_select_reg, n)] = 1'b1;
		end
	end

	// Every output carries a source, so routing alone never frees an output
	wire [3:0] auto_unused_shutdown_out = 4'h0;

	always_comb begin
		for (int n = 0; n < 4; n++) begin
			out_source[n] = xcfg_sel_type'(field_of(route_select_reg, n));
			tx_emphasis[n] = emphasis_pin_override ?
				xcfg_level_type'(field_of(tx_emphasis_level_reg, n)) :
				(emph_reg[n] ? xcfg_level_type'(`XCFG_PIN_EMPH_ON) : XCFG_LVL_OFF);
			rx_equalizer[n] = eq_pin_override ?
				xcfg_level_type'(field_of(rx_equalizer_level_reg, n)) :
				(eq_reg[n] ? xcfg_level_type'(`XCFG_PIN_EQ_ON) : XCFG_LVL_OFF);
		end
	end

	// Output gating follows power mode and keep-on bit; routing never gates it
	assign output_enable = powered_now ? (~auto_unused_shutdown_out & keep_on) : 4'h0;
	// Monitoring keeps receivers up even in power down
	assign input_enable = input_monitor_enable ? 4'hf :
		(powered_now ? input_used : 4'h0);
	assign input_monitor_on = input_monitor_enable;
	assign device_powered = powered_now;

	// Read mux; reserved status bits read zero
	always_comb begin
		case (reg_addr)
			`XCFG_ADDR_ROUTE: reg_rd_data_next = route_select_reg;
			`XCFG_ADDR_EMPH: reg_rd_data_next = tx_emphasis_level_reg;
			`XCFG_ADDR_EQ: reg_rd_data_next = rx_equalizer_level_reg;
			`XCFG_ADDR_CTRL: reg_rd_data_next = power_and_override_control_reg;
			`XCFG_ADDR_STATUS: reg_rd_data_next = {4'h0, los_reg};
			default: reg_rd_data_next = 8'h00;
		endcase
	end
	assign reg_rd_data = reg_rd_data_reg;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			route_select_reg <= `XCFG_RST_ROUTE;
			tx_emphasis_level_reg <= `XCFG_RST_EMPH;
			rx_equalizer_level_reg <= `XCFG_RST_EQ;
			power_and_override_control_reg <= `XCFG_RST_CTRL;
		end else begin
			// Status and unmapped indices have no write path
			if (wr_route) route_select_reg <= reg_wr_data;
			if (wr_emph) tx_emphasis_level_reg <= reg_wr_data;
			if (wr_eq) rx_equalizer_level_reg <= reg_wr_data;
			if (wr_ctrl) power_and_override_control_reg <= reg_wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_data_reg <= 8'h00;
		end else if (reg_rd_stb) begin
			reg_rd_data_reg <= reg_rd_data_next;
		end
	end

	// Pin synchronisers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			emph_sync1_reg <= 4'h0;
			emph_sync2_reg <= 4'h0;
			emph_sync3_reg <= 4'h0;
			eq_sync1_reg <= 4'h0;
			eq_sync2_reg <= 4'h0;
			eq_sync3_reg <= 4'h0;
			los_sync1_reg <= 4'h0;
			los_sync2_reg <= 4'h0;
			los_sync3_reg <= 4'h0;
			pwr_sync1_reg <= 1'b0;
			pwr_sync2_reg <= 1'b0;
			pwr_sync3_reg <= 1'b0;
		end else begin
			emph_sync1_reg <= emphasis_sel_pin;
			emph_sync2_reg <= emph_sync1_reg;
			emph_sync3_reg <= emph_sync2_reg;
			eq_sync1_reg <= eq_sel_pin;
			eq_sync2_reg <= eq_sync1_reg;
			eq_sync3_reg <= eq_sync2_reg;
			los_sync1_reg <= input_signal_valid;
			los_sync2_reg <= los_sync1_reg;
			los_sync3_reg <= los_sync2_reg;
			pwr_sync1_reg <= power_pin_on;
			pwr_sync2_reg <= pwr_sync1_reg;
			pwr_sync3_reg <= pwr_sync2_reg;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			emph_reg <= 4'h0;
			eq_reg <= 4'h0;
			los_reg <= 4'h0;
			pwr_reg <= 1'b0;
		end else begin
			emph_reg <= filt(emph_sync2_reg, emph_sync3_reg, emph_reg);
			eq_reg <= filt(eq_sync2_reg, eq_sync3_reg, eq_reg);
			los_reg <= filt(los_sync2_reg, los_sync3_reg, los_reg);
			pwr_reg <= (pwr_sync2_reg == pwr_sync3_reg) ? pwr_sync3_reg : pwr_reg;
		end
	end

endmodule

// File: xcfg_cfg_sva.sv
`timescale 1ns/1ps
module xcfg_cfg_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register access
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	input wire xcfg_pkg::xcfg_byte_type reg_addr,
	input wire xcfg_pkg::xcfg_byte_type reg_wr_data,
	input wire xcfg_pkg::xcfg_byte_type reg_rd_data,
	// Analog controls
	input wire logic device_powered,
	input wire logic [3:0] output_enable,
	input wire logic [3:0] input_enable,
	input wire logic input_monitor_on,
	input wire xcfg_pkg::xcfg_sel_type out_source [4]
);
	import xcfg_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	chk_soft_power_on: assert property (reg_wr_stb && reg_addr == 8'h03 && reg_wr_data[7]
		|=> device_powered) else $error("soft power on ignored");
	chk_keep_on_bits: assert property (reg_wr_stb && reg_addr == 8'h03
		|=> output_enable == ($past(reg_wr_data[3:0]) & {4{device_powered}}))
		else $error("output enable wrong after control write");
	chk_monitor_bit: assert property (reg_wr_stb && reg_addr == 8'h03
		|=> input_monitor_on == $past(reg_wr_data[6])) else $error("monitor bit wrong");
	chk_monitor_inputs: assert property (input_monitor_on |-> input_enable == 4'hf)
		else $error("input off while monitoring");
	chk_idle_inputs: assert property (!device_powered && !input_monitor_on
		|-> input_enable == 4'h0 && output_enable == 4'h0) else $error("enable while down");
	chk_route_fields: assert property (reg_wr_stb && reg_addr == 8'h00 |=>
		out_source[0] == $past(reg_wr_data[1:0]) && out_source[3] == $past(reg_wr_data[7:6]))
		else $error("route field wrong");
	chk_status_top: assert property (reg_rd_stb && reg_addr == 8'h04
		|=> reg_rd_data[7:4] == 4'h0) else $error("status reserved bits set");
	chk_unmapped_zero: assert property (reg_rd_stb && reg_addr > 8'h04
		|=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
	chk_read_hold: assert property (!reg_rd_stb |=> $stable(reg_rd_data))
		else $error("read data changed without read");
endmodule

bind xcfg_crosspoint_regs xcfg_cfg_sva u_xcfg_cfg_sva (.core_clk(core_clk), .reset_n(reset_n),
	.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
	.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .device_powered(device_powered),
	.output_enable(output_enable), .input_enable(input_enable),
	.input_monitor_on(input_monitor_on), .out_source(out_source));

// File: xcfg_host_model.sv
`timescale 1ns/1ps
module xcfg_host_model (
	// Clock
	input wire logic core_clk,
	// Register access
	output logic reg_wr_stb,
	output logic reg_rd_stb,
	output xcfg_pkg::xcfg_byte_type reg_addr,
	output xcfg_pkg::xcfg_byte_type reg_wr_data,
	input wire xcfg_pkg::xcfg_byte_type reg_rd_data
);
	import xcfg_pkg::*;
	initial begin
		reg_wr_stb = 1'b0;
		reg_rd_stb = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
	end
	// Data inverted after use so a stale byte is never mistaken for fresh
	task automatic write_reg(input xcfg_byte_type a, input xcfg_byte_type d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_stb = 1'b1;
		@(negedge core_clk);
		reg_wr_stb = 1'b0;
		reg_wr_data = ~d;
	endtask
	task automatic read_reg(input xcfg_byte_type a, output xcfg_byte_type d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd_stb = 1'b1;
		@(negedge core_clk);
		d = reg_rd_data;
		reg_rd_stb = 1'b0;
	endtask
endmodule

// File: crosspoint_config_registers_tb.sv
`timescale 1ns/1ps
module crosspoint_config_registers_tb;
	import xcfg_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic reg_wr_stb, reg_rd_stb, device_powered, input_monitor_on;
	xcfg_byte_type reg_addr, reg_wr_data, reg_rd_data, rd_val;
	logic power_pin_on = 1'b0;
	logic [3:0] emphasis_sel_pin = 4'h5;
	logic [3:0] eq_sel_pin = 4'h3;
	logic [3:0] input_signal_valid = 4'ha;
	logic [3:0] output_enable, input_enable;
	xcfg_sel_type out_source [4];
	xcfg_level_type tx_emphasis [4], rx_equalizer [4];
	int err_count = 0;
	int check_count = 0;
	always #25 core_clk = ~core_clk;
	xcfg_host_model u_xcfg_host_model (.core_clk(core_clk), .reg_wr_stb(reg_wr_stb),
		.reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_rd_data(reg_rd_data));
	xcfg_crosspoint_regs u_xcfg_crosspoint_regs (.core_clk(core_clk), .reset_n(reset_n),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .power_pin_on(power_pin_on),
		.emphasis_sel_pin(emphasis_sel_pin), .eq_sel_pin(eq_sel_pin),
		.input_signal_valid(input_signal_valid), .device_powered(device_powered),
		.output_enable(output_enable), .input_enable(input_enable),
		.input_monitor_on(input_monitor_on), .out_source(out_source),
		.tx_emphasis(tx_emphasis), .rx_equalizer(rx_equalizer));
	task automatic chk(input string n, input xcfg_byte_type e, input xcfg_byte_type g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input xcfg_byte_type a, input xcfg_byte_type d);
		u_xcfg_host_model.write_reg(a, d);
	endtask
	task automatic rd(input xcfg_byte_type a, input xcfg_byte_type e);
		u_xcfg_host_model.read_reg(a, rd_val);
		chk("read", e, rd_val);
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Whole run is under a hundred cycles
	initial begin
		#100us;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(negedge core_clk);
		reset_n = 1'b1;
		for (int a = 0; a < 4; a++) rd(8'(a), (a == 3) ? 8'h0f : 8'h00);
		chk("powered", 8'h00, {7'h0, device_powered});
		chk("emph", 8'h02, {6'h0, tx_emphasis[0]});
		chk("eq", 8'h01, {6'h0, rx_equalizer[1]});
		for (int a = 0; a < 3; a++) begin
			wr(8'(a), 8'he4);
			rd(8'(a), 8'he4);
		end
		wr(8'h03, 8'hb0);
		for (int n = 0; n < 4; n++) begin
			chk("src", 8'(n), {6'h0, out_source[n]});
			chk("emph", 8'(n), {6'h0, tx_emphasis[n]});
			chk("eq", 8'(n), {6'h0, rx_equalizer[n]});
		end
		chk("oe", 8'h00, {4'h0, output_enable});
		wr(8'h00, 8'h00);
		wr(8'h03, 8'h8f);
		chk("oe", 8'h0f, {4'h0, output_enable});
		chk("ie", 8'h01, {4'h0, input_enable});
		wr(8'h03, 8'hcf);
		chk("ie", 8'h0f, {4'h0, input_enable});
		chk("mon", 8'h01, {7'h0, input_monitor_on});
		wr(8'h03, 8'h0f);
		chk("powered", 8'h00, {7'h0, device_powered});
		power_pin_on = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("powered", 8'h01, {7'h0, device_powered});
		chk("oe", 8'h0f, {4'h0, output_enable});
		rd(8'h04, 8'h0a);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'h0a);
		wr(8'h07, 8'h55);
		rd(8'h07, 8'h00);
		rd(8'h03, 8'h0f);
		report_and_stop();
	end
endmodule
